/* timer_pair_pkg.sv */
// Purpose: Shared constants for the cascadable timer pair
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package timer_pair_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int PRE_W  = 8;
    localparam int STAT_W = 2;

    localparam logic [ADDR_W-1:0] LOW_CTRL_ADDR   = 8'h00;
    localparam logic [ADDR_W-1:0] HIGH_CTRL_ADDR  = 8'h04;
    localparam logic [ADDR_W-1:0] LOW_COUNT_ADDR  = 8'h08;
    localparam logic [ADDR_W-1:0] HIGH_COUNT_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] LOW_PER_ADDR    = 8'h10;
    localparam logic [ADDR_W-1:0] HIGH_PER_ADDR   = 8'h14;
    localparam logic [ADDR_W-1:0] HOLD_ADDR       = 8'h18;
    localparam logic [ADDR_W-1:0] STATUS_ADDR     = 8'h1C;
    localparam logic [ADDR_W-1:0] MASK_ADDR       = 8'h20;

    localparam int RUN_BIT       = 15;
    localparam int IDLE_STOP_BIT = 13;
    localparam int GATE_BIT      = 6;
    localparam int PRESC_LSB     = 4;
    localparam int PAIR_WIDE_BIT = 3;
    localparam int CLK_SRC_BIT   = 1;

    localparam logic [WORD_W-1:0] LOW_CTRL_MASK  = 16'hA07A;
    localparam logic [WORD_W-1:0] HIGH_CTRL_MASK = 16'hA072;
    localparam logic [WORD_W-1:0] CTRL_RESET     = 16'h0000;
    localparam logic [WORD_W-1:0] PERIOD_RESET   = 16'hFFFF;

    localparam int ST_LOW  = 0;
    localparam int ST_HIGH = 1;

    localparam logic [1:0] PRESC_1   = 2'h0;
    localparam logic [1:0] PRESC_8   = 2'h1;
    localparam logic [1:0] PRESC_64  = 2'h2;
    localparam logic [1:0] PRESC_256 = 2'h3;
    localparam logic [PRE_W-1:0] TERM_1   = 8'h00;
    localparam logic [PRE_W-1:0] TERM_8   = 8'h07;
    localparam logic [PRE_W-1:0] TERM_64  = 8'h3F;
    localparam logic [PRE_W-1:0] TERM_256 = 8'hFF;
endpackage : timer_pair_pkg

/* timer_tick_source.sv */
// Purpose: Counting-clock select with gating for one timer
// Assumes: Count pin synchronous to the system clock
// Notes:   Internal source is a half-rate strobe from the top
`timescale 1ns/1ps
module timer_tick_source (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    input  wire logic ext_sel_i,
    input  wire logic gate_en_i,
    input  wire logic half_tick_i,
    output logic      tick_o
);
    logic pin_d_reg;
    logic pin_d_next;

    always_comb begin
        pin_d_next = pin_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_d_reg <= 1'b0;
        end else if (ce_i) begin
            pin_d_reg <= pin_d_next;
        end
    end

    always_comb begin
        if (ext_sel_i) begin
            tick_o = pin_i & ~pin_d_reg;
        end else begin
            tick_o = half_tick_i & (~gate_en_i | pin_i);
        end
    end
endmodule : timer_tick_source

/* timer_prescaler.sv */
// Purpose: Programmable 1/8/64/256 divider of counting ticks
// Assumes: Clear has priority over counting
// Notes:   Output is a combinational strobe
`timescale 1ns/1ps
module timer_prescaler
    import timer_pair_pkg::*;
#(
    parameter int PW = timer_pair_pkg::PRE_W
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       tick_i,
    input  wire logic [1:0] sel_i,
    input  wire logic       clr_i,
    output logic            tick_o
);
    logic [PW-1:0] cnt_reg;
    logic [PW-1:0] cnt_next;
    logic [PW-1:0] term;

    always_comb begin
        case (sel_i)
            PRESC_1:   term = PW'(TERM_1);
            PRESC_8:   term = PW'(TERM_8);
            PRESC_64:  term = PW'(TERM_64);
            PRESC_256: term = PW'(TERM_256);
            default:   term = PW'(TERM_1);
        endcase
        tick_o   = tick_i & (cnt_reg == term);
        cnt_next = cnt_reg;
        if (clr_i) begin
            cnt_next = '0;
        end else if (tick_i) begin
            cnt_next = (cnt_reg == term) ? '0 : PW'(cnt_reg + 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : timer_prescaler

/* cascadable_timer_pair.sv */
// Purpose: Two 16-bit timers, cascadable into one 32-bit timer, on APB
// Assumes: Pins synchronous to SYS_CLK_I; IDLE_I is the device idle level
// Notes:   Internal count clock is half of SYS_CLK_I
// Functional notes
// - In 32-bit mode the low run bit starts and stops the pair.
// - In 16-bit mode each timer starts and stops on its own run bit.
// - Idle-stop set halts the timer during idle; clear keeps it running.
// - Gate bit enables gated accumulation on internal clock; ignored on external.
// - Prescale field selects 1:1, 1:8, 1:64 or 1:256.
// - Pair-wide mode bit joins both timers into one 32-bit timer.
// - Low clock-source bit picks external rising edges or internal half clock.
// - In 16-bit mode the high clock-source bit selects its own source.
// - In 32-bit mode the high control register has no effect.
// - Control write while running clears that prescaler; avoid it.
// - Only the high timer raises the converter trigger in 16-bit mode.
// - Unimplemented control bits read zero and ignore writes.
// - In 32-bit mode high count is upper word, low count lower word.
// - In 32-bit mode high period is upper, low period lower match word.
// - In 32-bit mode low clock drives pair; match sets high flag.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module cascadable_timer_pair
    import timer_pair_pkg::*;
(
    input  wire logic                              SYS_CLK_I,
    input  wire logic                              RESETN_I,
    input  wire logic                              CLK_EN_I,
    input  wire logic                              IDLE_I,
    input  wire logic                              LOW_EXT_COUNT_PIN_I,
    input  wire logic                              HIGH_EXT_COUNT_PIN_I,
    input  wire logic                              PSEL_I,
    input  wire logic                              PENABLE_I,
    input  wire logic                              PWRITE_I,
    input  wire logic [timer_pair_pkg::ADDR_W-1:0] PADDR_I,
    input  wire logic [timer_pair_pkg::DATA_W-1:0] PWDATA_I,
    output logic      [timer_pair_pkg::DATA_W-1:0] PRDATA_O,
    output logic                                   PREADY_O,
    output logic                                   PSLVERR_O,
    output logic                                   IRQ_O,
    output logic                                   ADC_TRIG_O
);
    // Reset release synchroniser; async assert, clocked release
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else if (CLK_EN_I) begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    logic [WORD_W-1:0] lo_ctrl_reg,  lo_ctrl_next;
    logic [WORD_W-1:0] hi_ctrl_reg,  hi_ctrl_next;
    logic [WORD_W-1:0] lo_cnt_reg,   lo_cnt_next;
    logic [WORD_W-1:0] hi_cnt_reg,   hi_cnt_next;
    logic [WORD_W-1:0] lo_per_reg,   lo_per_next;
    logic [WORD_W-1:0] hi_per_reg,   hi_per_next;
    logic [WORD_W-1:0] hold_reg,     hold_next;
    logic [STAT_W-1:0] stat_reg,     stat_next;
    logic [STAT_W-1:0] mask_reg,     mask_next;
    logic [DATA_W-1:0] rdata_reg,    rdata_next;
    logic              ready_reg,    ready_next;
    logic              slverr_reg,   slverr_next;
    logic              irq_reg,      irq_next;
    logic              trig_reg,     trig_next;
    logic              half_reg,     half_next;

    logic              mode32;
    logic              lo_run;
    logic              hi_run;
    logic              lo_raw;
    logic              hi_raw;
    logic              lo_ptick;
    logic              hi_ptick;
    logic              lo_clr;
    logic              hi_clr;
    logic              access;
    logic              wr;
    logic              rd;
    logic [STAT_W-1:0] events;
    logic [31:0]       cnt32;
    logic [31:0]       per32;
    logic [31:0]       cnt32_inc;

    assign mode32 = lo_ctrl_reg[PAIR_WIDE_BIT];
    assign lo_run = lo_ctrl_reg[RUN_BIT]
                  & ~(IDLE_I & lo_ctrl_reg[IDLE_STOP_BIT]);
    assign hi_run = ~mode32 & hi_ctrl_reg[RUN_BIT]
                  & ~(IDLE_I & hi_ctrl_reg[IDLE_STOP_BIT]);
    assign access = PSEL_I & PENABLE_I & ~ready_reg;
    assign wr     = access & PWRITE_I;
    assign rd     = access & ~PWRITE_I;
    assign lo_clr = wr & (PADDR_I == LOW_CTRL_ADDR)
                  & lo_ctrl_reg[RUN_BIT];
    assign hi_clr = wr & (PADDR_I == HIGH_CTRL_ADDR)
                  & hi_ctrl_reg[RUN_BIT];
    assign cnt32     = {hi_cnt_reg, lo_cnt_reg};
    assign per32     = {hi_per_reg, lo_per_reg};
    assign cnt32_inc = cnt32 + 32'h0000_0001;

    // Half-rate strobe stands in for the internal instruction clock
    always_comb begin
        half_next = ~half_reg;
    end

    timer_tick_source u_lo_src (
        .clk_i       (SYS_CLK_I),
        .rst_n_i     (rst_n_reg),
        .ce_i        (CLK_EN_I),
        .pin_i       (LOW_EXT_COUNT_PIN_I),
        .ext_sel_i   (lo_ctrl_reg[CLK_SRC_BIT]),
        .gate_en_i   (lo_ctrl_reg[GATE_BIT]),
        .half_tick_i (half_reg),
        .tick_o      (lo_raw)
    );

    timer_tick_source u_hi_src (
        .clk_i       (SYS_CLK_I),
        .rst_n_i     (rst_n_reg),
        .ce_i        (CLK_EN_I),
        .pin_i       (HIGH_EXT_COUNT_PIN_I),
        .ext_sel_i   (hi_ctrl_reg[CLK_SRC_BIT]),
        .gate_en_i   (hi_ctrl_reg[GATE_BIT]),
        .half_tick_i (half_reg),
        .tick_o      (hi_raw)
    );

    timer_prescaler #(.PW(PRE_W)) u_lo_pre (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (rst_n_reg),
        .ce_i    (CLK_EN_I),
        .tick_i  (lo_raw & lo_run),
        .sel_i   (lo_ctrl_reg[PRESC_LSB +: 2]),
        .clr_i   (lo_clr),
        .tick_o  (lo_ptick)
    );

    timer_prescaler #(.PW(PRE_W)) u_hi_pre (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (rst_n_reg),
        .ce_i    (CLK_EN_I),
        .tick_i  (hi_raw & hi_run),
        .sel_i   (hi_ctrl_reg[PRESC_LSB +: 2]),
        .clr_i   (hi_clr),
        .tick_o  (hi_ptick)
    );

    // Counting; bus writes to count words win over a same-cycle tick
    always_comb begin
        lo_cnt_next = lo_cnt_reg;
        hi_cnt_next = hi_cnt_reg;
        events      = '0;
        trig_next   = 1'b0;
        if (mode32) begin
            if (lo_ptick) begin
                if (cnt32 == per32) begin
                    lo_cnt_next     = '0;
                    hi_cnt_next     = '0;
                    events[ST_HIGH] = 1'b1;
                    trig_next       = 1'b1;
                end else begin
                    lo_cnt_next = cnt32_inc[WORD_W-1:0];
                    hi_cnt_next = cnt32_inc[31:WORD_W];
                end
            end
        end else begin
            if (lo_ptick) begin
                if (lo_cnt_reg == lo_per_reg) begin
                    lo_cnt_next    = '0;
                    events[ST_LOW] = 1'b1;
                end else begin
                    lo_cnt_next = WORD_W'(lo_cnt_reg + 1'b1);
                end
            end
            if (hi_ptick) begin
                if (hi_cnt_reg == hi_per_reg) begin
                    hi_cnt_next     = '0;
                    events[ST_HIGH] = 1'b1;
                    trig_next       = 1'b1;
                end else begin
                    hi_cnt_next = WORD_W'(hi_cnt_reg + 1'b1);
                end
            end
        end
        if (wr && PADDR_I == LOW_COUNT_ADDR) begin
            lo_cnt_next = PWDATA_I[WORD_W-1:0];
        end
        if (wr && PADDR_I == HIGH_COUNT_ADDR) begin
            hi_cnt_next = PWDATA_I[WORD_W-1:0];
        end
    end

    // Register file and APB slave: one wait state on every access
    always_comb begin
        lo_ctrl_next = lo_ctrl_reg;
        hi_ctrl_next = hi_ctrl_reg;
        lo_per_next  = lo_per_reg;
        hi_per_next  = hi_per_reg;
        hold_next    = hold_reg;
        mask_next    = mask_reg;
        rdata_next   = rdata_reg;
        slverr_next  = 1'b0;
        ready_next   = access;
        // Set wins over a same-cycle write-one clear
        stat_next    = stat_reg;
        if (wr && PADDR_I == STATUS_ADDR) begin
            stat_next = stat_reg & ~PWDATA_I[STAT_W-1:0];
        end
        stat_next = stat_next | events;
        irq_next  = |(stat_reg & mask_reg);
        if (wr) begin
            case (PADDR_I)
                LOW_CTRL_ADDR:   lo_ctrl_next =
                    PWDATA_I[WORD_W-1:0] & LOW_CTRL_MASK;
                HIGH_CTRL_ADDR:  hi_ctrl_next =
                    PWDATA_I[WORD_W-1:0] & HIGH_CTRL_MASK;
                LOW_PER_ADDR:    lo_per_next = PWDATA_I[WORD_W-1:0];
                HIGH_PER_ADDR:   hi_per_next = PWDATA_I[WORD_W-1:0];
                MASK_ADDR:       mask_next   = PWDATA_I[STAT_W-1:0];
                LOW_COUNT_ADDR,
                HIGH_COUNT_ADDR,
                HOLD_ADDR,
                STATUS_ADDR: begin
                end
                default:         slverr_next = 1'b1;
            endcase
        end
        if (rd) begin
            rdata_next = '0;
            case (PADDR_I)
                LOW_CTRL_ADDR:   rdata_next[WORD_W-1:0] = lo_ctrl_reg;
                HIGH_CTRL_ADDR:  rdata_next[WORD_W-1:0] = hi_ctrl_reg;
                LOW_COUNT_ADDR: begin
                    rdata_next[WORD_W-1:0] = lo_cnt_reg;
                    if (mode32) begin
                        hold_next = hi_cnt_reg;
                    end
                end
                HIGH_COUNT_ADDR: rdata_next[WORD_W-1:0] = hi_cnt_reg;
                LOW_PER_ADDR:    rdata_next[WORD_W-1:0] = lo_per_reg;
                HIGH_PER_ADDR:   rdata_next[WORD_W-1:0] = hi_per_reg;
                HOLD_ADDR:       rdata_next[WORD_W-1:0] = hold_reg;
                STATUS_ADDR:     rdata_next[STAT_W-1:0] = stat_reg;
                MASK_ADDR:       rdata_next[STAT_W-1:0] = mask_reg;
                default:         slverr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lo_ctrl_reg <= CTRL_RESET;
            hi_ctrl_reg <= CTRL_RESET;
            lo_cnt_reg  <= '0;
            hi_cnt_reg  <= '0;
            lo_per_reg  <= PERIOD_RESET;
            hi_per_reg  <= PERIOD_RESET;
            hold_reg    <= '0;
            stat_reg    <= '0;
            mask_reg    <= '0;
            rdata_reg   <= '0;
            ready_reg   <= 1'b0;
            slverr_reg  <= 1'b0;
            irq_reg     <= 1'b0;
            trig_reg    <= 1'b0;
            half_reg    <= 1'b0;
        end else if (CLK_EN_I) begin
            lo_ctrl_reg <= lo_ctrl_next;
            hi_ctrl_reg <= hi_ctrl_next;
            lo_cnt_reg  <= lo_cnt_next;
            hi_cnt_reg  <= hi_cnt_next;
            lo_per_reg  <= lo_per_next;
            hi_per_reg  <= hi_per_next;
            hold_reg    <= hold_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            rdata_reg   <= rdata_next;
            ready_reg   <= ready_next;
            slverr_reg  <= slverr_next;
            irq_reg     <= irq_next;
            trig_reg    <= trig_next;
            half_reg    <= half_next;
        end
    end

    assign PRDATA_O   = rdata_reg;
    assign PREADY_O   = ready_reg;
    assign PSLVERR_O  = slverr_reg;
    assign IRQ_O      = irq_reg;
    assign ADC_TRIG_O = trig_reg;
endmodule : cascadable_timer_pair

/* timer_pair_chk.sv */
// Purpose: Port-level checks for the timer pair
// Assumes: One clock domain, APB slave with one wait state
// Notes:   Counting behaviour is judged by the bench
`timescale 1ns/1ps
module timer_pair_chk
    import timer_pair_pkg::*;
(
    input wire logic                              SYS_CLK_I,
    input wire logic                              RESETN_I,
    input wire logic                              PSEL_I,
    input wire logic                              PENABLE_I,
    input wire logic                              PWRITE_I,
    input wire logic [timer_pair_pkg::ADDR_W-1:0] PADDR_I,
    input wire logic [timer_pair_pkg::DATA_W-1:0] PRDATA_O,
    input wire logic                              PREADY_O,
    input wire logic                              PSLVERR_O,
    input wire logic                              ADC_TRIG_O
);
    import timer_pair_pkg::*;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);
    logic acc;
    logic rd;
    logic mapped;
    assign acc = PSEL_I && PENABLE_I && !PREADY_O;
    assign rd = acc && !PWRITE_I;
    assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= MASK_ADDR);

    ready_lat_a: assert property (acc |=> PREADY_O)
        else $error("No ready one cycle after access");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("Ready held longer than one cycle");
    ready_cause_a: assert property (PREADY_O |-> $past(acc))
        else $error("Ready without an access");
    err_map_a: assert property (acc && !mapped |=> PSLVERR_O)
        else $error("Unmapped access not refused");
    err_ok_a: assert property (acc && mapped |=> !PSLVERR_O)
        else $error("Mapped access refused");
    rdata_up_a: assert property (PREADY_O |-> PRDATA_O[31:16] == 16'h0000)
        else $error("Upper read data not zero");
    low_ctrl_a: assert property (rd && PADDR_I == LOW_CTRL_ADDR
        |=> (PRDATA_O[15:0] & ~LOW_CTRL_MASK) == 16'h0000)
        else $error("Low control reads unused bits");
    high_ctrl_a: assert property (rd && PADDR_I == HIGH_CTRL_ADDR
        |=> (PRDATA_O[15:0] & ~HIGH_CTRL_MASK) == 16'h0000)
        else $error("High control reads unused bits");
    stat_bits_a: assert property (rd && PADDR_I == STATUS_ADDR
        |=> PRDATA_O[15:2] == 14'h0000)
        else $error("Status reads unused bits");
    trig_pulse_a: assert property (ADC_TRIG_O |=> !ADC_TRIG_O)
        else $error("Trigger longer than one cycle");
endmodule : timer_pair_chk

bind cascadable_timer_pair timer_pair_chk chk_i (
    .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .ADC_TRIG_O(ADC_TRIG_O)
);

/* count_pin_model.sv */
// Purpose: External count and gate pins of the timer pair
// Assumes: Pins change just after a rising system clock edge
// Notes:   Pins rest low between bursts
`timescale 1ns/1ps
module count_pin_model (
    input  wire logic clk_i,
    output logic      low_pin_o,
    output logic      high_pin_o
);
    initial begin
        low_pin_o = 1'b0;
        high_pin_o = 1'b0;
    end
    task automatic drive(input logic hi, input logic v);
        if (hi) begin
            high_pin_o <= v;
        end else begin
            low_pin_o <= v;
        end
    endtask : drive
    // Width w gives prompt (1) or slow edges; each level lasts w cycles
    task automatic pulses(input logic hi, input int n, input int w);
        repeat (n) begin
            drive(hi, 1'b1);
            repeat (w) @(posedge clk_i);
            drive(hi, 1'b0);
            repeat (w) @(posedge clk_i);
        end
    endtask : pulses
endmodule : count_pin_model

/* cascadable_timer_pair_tb.sv */
// Purpose: Self-checking bench for the timer pair
// Assumes: Internal count tick every second system clock
// Notes:   Exact counts only where pin edges or periods fix them
`timescale 1ns/1ps
module cascadable_timer_pair_tb;
    import timer_pair_pkg::*;
    logic              clk;
    logic              rst_n;
    logic              idle;
    logic              ce;
    logic              psel;
    logic              pen;
    logic              pwr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic              trig;
    logic              low_pin;
    logic              high_pin;
    logic [DATA_W-1:0] rv;
    logic              err_q;
    int                n_errors;
    int                samples_checked;

    cascadable_timer_pair uut (
        .SYS_CLK_I(clk), .RESETN_I(rst_n), .CLK_EN_I(ce), .IDLE_I(idle),
        .LOW_EXT_COUNT_PIN_I(low_pin), .HIGH_EXT_COUNT_PIN_I(high_pin),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .IRQ_O(irq), .ADC_TRIG_O(trig)
    );
    count_pin_model pins (
        .clk_i(clk), .low_pin_o(low_pin), .high_pin_o(high_pin)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until ready is sampled high, then released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) chk(32'h0, 32'h1);
        rv = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rv, e);
    endtask : rdc
    task automatic wait_trig(input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (trig !== 1'b1 && n < lim);
    endtask : wait_trig

    task automatic t_regs();
        rdc(LOW_CTRL_ADDR, 32'h0);
        rdc(HIGH_CTRL_ADDR, 32'h0);
        wr(LOW_CTRL_ADDR, 32'hFFFFFFFF);
        rdc(LOW_CTRL_ADDR, 32'h0000A07A);
        wr(HIGH_CTRL_ADDR, 32'hFFFFFFFF);
        rdc(HIGH_CTRL_ADDR, 32'h0000A072);
        wr(LOW_CTRL_ADDR, 32'h0);
        wr(HIGH_CTRL_ADDR, 32'h0);
        wr(8'h40, 32'h1);
        chk(32'(err_q), 32'h1);
    endtask : t_regs
    task automatic t_irq();
        wr(LOW_PER_ADDR, 32'h3);
        wr(LOW_COUNT_ADDR, 32'h0);
        wr(HIGH_COUNT_ADDR, 32'h0);
        wr(STATUS_ADDR, 32'h3);
        wr(LOW_CTRL_ADDR, 32'h8000);
        repeat (20) @(posedge clk);
        rdc(HIGH_COUNT_ADDR, 32'h0);
        rdc(STATUS_ADDR, 32'h1);
        chk(32'(irq), 32'h0);
        wr(MASK_ADDR, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        wr(LOW_CTRL_ADDR, 32'h0);
        apb(1'b0, LOW_COUNT_ADDR, 32'h0);
        chk(32'(rv <= 32'h3), 32'h1);
        wr(STATUS_ADDR, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        rdc(STATUS_ADDR, 32'h0);
    endtask : t_irq
    task automatic t_presc();
        int n;
        int div[4] = '{1, 8, 64, 256};
        wr(LOW_PER_ADDR, 32'h0);
        wr(HIGH_PER_ADDR, 32'h0);
        wr(LOW_COUNT_ADDR, 32'h0);
        wr(HIGH_COUNT_ADDR, 32'h0);
        wr(LOW_CTRL_ADDR, 32'h8000);
        wait_trig(40, n);
        chk(n, 40);
        wr(LOW_CTRL_ADDR, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(HIGH_CTRL_ADDR, 32'h8000 | (s << 4));
            wait_trig(600, n);
            wait_trig(600, n);
            chk(n, 2 * div[s]);
            wr(HIGH_CTRL_ADDR, 32'h0);
        end
    endtask : t_presc
    task automatic t_ext();
        wr(LOW_PER_ADDR, 32'hFFFF);
        wr(HIGH_PER_ADDR, 32'hFFFF);
        wr(LOW_COUNT_ADDR, 32'h0);
        wr(HIGH_COUNT_ADDR, 32'h0);
        wr(LOW_CTRL_ADDR, 32'h8042);
        wr(HIGH_CTRL_ADDR, 32'h8002);
        pins.pulses(1'b0, 5, 1);
        pins.pulses(1'b1, 3, 4);
        wr(LOW_CTRL_ADDR, 32'h0);
        wr(HIGH_CTRL_ADDR, 32'h0);
        rdc(LOW_COUNT_ADDR, 32'h5);
        rdc(HIGH_COUNT_ADDR, 32'h3);
        // Gate low: internal ticks must be held off
        wr(LOW_COUNT_ADDR, 32'h0);
        wr(LOW_CTRL_ADDR, 32'h8040);
        repeat (20) @(posedge clk);
        wr(LOW_CTRL_ADDR, 32'h0);
        rdc(LOW_COUNT_ADDR, 32'h0);
        pins.drive(1'b0, 1'b1);
        wr(LOW_CTRL_ADDR, 32'h8040);
        repeat (20) @(posedge clk);
        wr(LOW_CTRL_ADDR, 32'h0);
        pins.drive(1'b0, 1'b0);
        apb(1'b0, LOW_COUNT_ADDR, 32'h0);
        chk(32'(rv != 32'h0), 32'h1);
    endtask : t_ext
    task automatic t_idle();
        wr(LOW_COUNT_ADDR, 32'h0);
        wr(HIGH_COUNT_ADDR, 32'h0);
        idle <= 1'b1;
        wr(LOW_CTRL_ADDR, 32'hA000);
        wr(HIGH_CTRL_ADDR, 32'h8000);
        repeat (20) @(posedge clk);
        wr(LOW_CTRL_ADDR, 32'h0);
        wr(HIGH_CTRL_ADDR, 32'h0);
        idle <= 1'b0;
        rdc(LOW_COUNT_ADDR, 32'h0);
        apb(1'b0, HIGH_COUNT_ADDR, 32'h0);
        chk(32'(rv != 32'h0), 32'h1);
        // Enable low for fifty cycles: a free run would pass 25 counts
        wr(HIGH_COUNT_ADDR, 32'h0);
        wr(HIGH_CTRL_ADDR, 32'h8000);
        ce <= 1'b0;
        repeat (50) @(posedge clk);
        ce <= 1'b1;
        wr(HIGH_CTRL_ADDR, 32'h0);
        apb(1'b0, HIGH_COUNT_ADDR, 32'h0);
        chk(32'(rv < 32'h8), 32'h1);
    endtask : t_idle
    task automatic t_pair();
        int n;
        wr(LOW_PER_ADDR, 32'hFFFF);
        wr(HIGH_PER_ADDR, 32'hFFFF);
        wr(STATUS_ADDR, 32'h3);
        wr(LOW_CTRL_ADDR, 32'h0008);
        wr(HIGH_CTRL_ADDR, 32'h8000);
        wr(HIGH_COUNT_ADDR, 32'h0);
        wr(LOW_COUNT_ADDR, 32'hFFFF);
        wr(LOW_CTRL_ADDR, 32'h8008);
        repeat (4) @(posedge clk);
        wr(LOW_CTRL_ADDR, 32'h0008);
        apb(1'b0, LOW_COUNT_ADDR, 32'h0);
        chk(32'(rv < 32'h10), 32'h1);
        rdc(HOLD_ADDR, 32'h1);
        rdc(HIGH_COUNT_ADDR, 32'h1);
        // Match at 0001_0000 crosses the word boundary
        wr(LOW_PER_ADDR, 32'h0);
        wr(HIGH_PER_ADDR, 32'h1);
        wr(HIGH_COUNT_ADDR, 32'h0);
        wr(LOW_COUNT_ADDR, 32'hFFFE);
        wr(LOW_CTRL_ADDR, 32'h8008);
        wait_trig(100, n);
        chk(32'(n < 100), 32'h1);
        wr(LOW_CTRL_ADDR, 32'h0008);
        rdc(STATUS_ADDR, 32'h2);
        wr(LOW_CTRL_ADDR, 32'h0);
        wr(HIGH_CTRL_ADDR, 32'h0);
    endtask : t_pair

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        idle = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_irq();
        t_presc();
        t_ext();
        t_idle();
        t_pair();
        tally_and_finish();
    end
    // Run needs under ten thousand cycles; this allows fifty
    initial begin
        #500000;
        n_errors++;
        tally_and_finish();
    end
endmodule : cascadable_timer_pair_tb
